// ==== core/dpt_pkg.sv ====
// Constants and state type for the dual PWM timer block
package dpt_pkg;

  localparam int          T0_W        = 16;
  localparam int          TRI_W       = 14;
  localparam int          TRI_N       = 3;
  localparam logic [15:0] T0_RST_VAL  = 16'h0000;
  localparam logic [13:0] TRI_RST_VAL = 14'h0000;
  // Peripheral divider codes: 0 -> /1 (16 MHz) .. 3 -> /8 (2 MHz)
  localparam logic [1:0]  DIV_1       = 2'h0;
  localparam logic [1:0]  DIV_2       = 2'h1;
  localparam logic [1:0]  DIV_4       = 2'h2;
  localparam logic [1:0]  DIV_8       = 2'h3;
  localparam logic [2:0]  PRE_MAX     = 3'h7;
  // Ten timer ticks, from the slow or the fast clock, make one tick of the interrupt-period counter
  localparam logic [3:0]  DIV10_LAST  = 4'h9;

  typedef struct packed {
    logic        run;
    logic        phase_low;
    logic [15:0] main_cnt;
    logic [15:0] irq_cnt;
    logic [15:0] hi_shadow;
    logic [15:0] lo_shadow;
    logic [2:0]  fast_pre;
    logic        slow_sync1;
    logic        slow_sync2;
    logic        slow_prev;
    logic [3:0]  div10;
    logic        clk_half;
    logic        out_true;
    logic        out_inv;
    logic        irq;
    logic [2:0]  tri_pre;
    logic        tri_run;
    logic [13:0] tri_period_counter;
    logic [13:0] tri_duty_counter;
    logic [2:0]  tri_out;
    logic        rx_s1;
    logic        rx_s2;
    logic        tx_s1;
    logic        tx_s2;
  } dpt_state_type;

endpackage

// ==== core/dpt_top.sv ====
// Dual PWM timer: complementary PWM timer and triple PWM generator
`timescale 1ns/1ps

//Function
// RULE1: Run bit loads main counter from high reload, period counter from its reload.
// RULE2: Main counter at zero reloads alternately from high and low shadow values.
// RULE3: True output high in high phase, low in low phase; second output inverted.
// RULE4: Clock output mode toggles outputs at timer clock over two in high phase.
// RULE5: Period counter holds zero until low-phase end; then interrupt and full reload.
// RULE6: Shadows take new reload values only at end of low phase, both zero.
// RULE7: Counters and reload registers are zero after reset.
// RULE8: Starting the timer raises the period interrupt immediately.
// RULE9: Disabled timer holds all state in reset except the three reload values; the fast prescaler keeps counting and the inverted output is high.
// RULE10: Live counter views: period counter and main counter readouts.
// RULE11: 32 kHz default; fast select plus clock on picks 16, 8, 4, 2 MHz.
// RULE12: Extra divider slows only the period counter by ten.
// RULE13: Freeze flag stops both counters until cleared.
// RULE14: Counters and reloads are 16 bits, phase lasts value plus one clocks.
// RULE15: Triple PWM 14-bit counter on system clock over 1, 2, 4, 8; enable gated.
// RULE16: Period counter counts down, at zero sets all outputs high and reloads.
// RULE17: Duty counter counts up; match drives output low; held while period zero.
// RULE18: Each output has its own duty threshold for 0 to 100 percent duty; a threshold equal to the period still leaves the output low for one tick.
// RULE19: Software keeps every duty threshold no greater than the period value.
// RULE20: Radio pause freezes duty counter and forces outputs low during activity.
// RULE21: Clearing auto pause allow disables the radio-driven freeze.
// RULE22: Radio activity signals pass a two-stage synchronizer before use.
module dpt_top
  import dpt_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_nrst,
  input  wire logic              i_slow_clk,
  input  wire logic              i_t0_run,
  input  wire logic              i_t0_fast_clock_select,
  input  wire logic              i_periph_timer_clock_on,
  input  wire logic [1:0]        i_periph_timer_divider,
  input  wire logic              i_irq_counter_div10,
  input  wire logic              i_t0_clock_mode,
  input  wire logic              i_t0_freeze,
  input  wire logic [T0_W-1:0]   i_high_phase_reload,
  input  wire logic [T0_W-1:0]   i_low_phase_reload,
  input  wire logic [T0_W-1:0]   i_irq_period_reload,
  input  wire logic              i_tri_on,
  input  wire logic [TRI_W-1:0]  i_tri_period_value,
  input  wire logic [TRI_W-1:0]  i_tri_duty_threshold_0,
  input  wire logic [TRI_W-1:0]  i_tri_duty_threshold_1,
  input  wire logic [TRI_W-1:0]  i_tri_duty_threshold_2,
  input  wire logic              i_radio_pause_enable,
  input  wire logic              i_auto_pause_allow,
  input  wire logic              i_radio_rx_active,
  input  wire logic              i_radio_tx_active,
  output logic                   o_t0_out_true,
  output logic                   o_t0_out_inverted,
  output logic                   o_t0_period_irq,
  output logic [T0_W-1:0]        o_irq_period_view,
  output logic [T0_W-1:0]        o_main_count_view,
  output logic [TRI_N-1:0]       o_tri_out_n
);

  dpt_state_type s_q;
  dpt_state_type s_d;
  logic [TRI_W-1:0] thr [TRI_N];
  logic             fast_tick;
  logic             slow_tick;
  logic             t0_tick;
  logic             irq_tick;
  logic             tri_tick;
  logic             paused;
  logic [2:0]       pre_mask;
  logic             main_zero;
  logic             irq_zero;
  logic             tri_reload;
  logic [TRI_W-1:0] duty_nxt;
  logic [TRI_N-1:0] thr_hit;

  assign thr[0] = i_tri_duty_threshold_0;
  assign thr[1] = i_tri_duty_threshold_1;
  assign thr[2] = i_tri_duty_threshold_2;

  // ************************************************************
  // Ticks and flags
  // ************************************************************
  always_comb
  begin
    case (i_periph_timer_divider)
      DIV_1:   pre_mask = 3'h0;
      DIV_2:   pre_mask = 3'h1;
      DIV_4:   pre_mask = 3'h3;
      DIV_8:   pre_mask = PRE_MAX;
      default: pre_mask = PRE_MAX;
    endcase
    // RULE15: system clock divider
    tri_tick  = ((s_q.tri_pre & pre_mask) == 3'h0);
    fast_tick = ((s_q.fast_pre & pre_mask) == 3'h0);
    slow_tick = s_q.slow_sync2 & ~s_q.slow_prev;
    // RULE11: clock source selection
    t0_tick = (i_t0_fast_clock_select && i_periph_timer_clock_on) ?
              fast_tick : slow_tick;
    // RULE13: freeze stops counting
    if (i_t0_freeze)
    begin
      t0_tick = 1'b0;
    end
    // RULE12: period counter only, divide by ten
    irq_tick = t0_tick;
    if (i_irq_counter_div10 && t0_tick)
    begin
      irq_tick = (s_q.div10 == DIV10_LAST);
    end
    main_zero = (s_q.main_cnt == T0_RST_VAL);
    irq_zero  = (s_q.irq_cnt == T0_RST_VAL);
    // RULE20: pause from synchronised activity
    // RULE21: allow bit gates the pause
    paused = i_radio_pause_enable && i_auto_pause_allow &&
             (s_q.rx_s2 || s_q.tx_s2);
    // RULE16: period counter reload point
    tri_reload = tri_tick && (s_q.tri_period_counter == TRI_RST_VAL);
    // RULE17: duty next value, held while period is zero
    if (!i_tri_on || !s_q.tri_run || tri_reload ||
        (i_tri_period_value == TRI_RST_VAL))
    begin
      duty_nxt = TRI_RST_VAL;
    end
    else if (tri_tick && !paused)
    begin
      duty_nxt = s_q.tri_duty_counter + 14'h0001;
    end
    else
    begin
      duty_nxt = s_q.tri_duty_counter;
    end
  end

  // ************************************************************
  // Duty threshold compare
  // ************************************************************
  // RULE18: one comparator per output
  for (genvar k = 0; k < TRI_N; k++)
  begin : g_thr
    assign thr_hit[k] = (duty_nxt == thr[k]) &&
                        !(tri_reload && (thr[k] != TRI_RST_VAL));
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    s_d = s_q;
    // Shared prescalers
    s_d.fast_pre = s_q.fast_pre + 3'h1;
    s_d.tri_pre  = s_q.tri_pre + 3'h1;
    // Slow clock synchronizer
    s_d.slow_sync1 = i_slow_clk;
    s_d.slow_sync2 = s_q.slow_sync1;
    s_d.slow_prev  = s_q.slow_sync2;
    // RULE12: divide-by-ten prescaler
    if (i_irq_counter_div10 && t0_tick)
    begin
      s_d.div10 = (s_q.div10 == DIV10_LAST) ? 4'h0 : s_q.div10 + 4'h1;
    end
    s_d.irq = 1'b0;

    // ************************************************************
    // Timer 0
    // ************************************************************
    if (!i_t0_run)
    begin
      // RULE9: disabled state is reset, reload inputs kept outside
      s_d.run       = 1'b0;
      s_d.phase_low = 1'b0;
      s_d.main_cnt  = T0_RST_VAL;
      s_d.irq_cnt   = T0_RST_VAL;
      s_d.hi_shadow = T0_RST_VAL;
      s_d.lo_shadow = T0_RST_VAL;
      s_d.div10     = 4'h0;
      s_d.clk_half  = 1'b0;
    end
    else if (!s_q.run)
    begin
      // RULE1: start loads counters
      s_d.run       = 1'b1;
      // RULE8: start raises interrupt
      s_d.irq       = 1'b1;
      s_d.phase_low = 1'b0;
      s_d.main_cnt  = i_high_phase_reload;
      s_d.irq_cnt   = i_irq_period_reload;
      s_d.hi_shadow = i_high_phase_reload;
      s_d.lo_shadow = i_low_phase_reload;
    end
    else if (t0_tick)
    begin
      s_d.clk_half = ~s_q.clk_half;
      // RULE5: period end only at end of low phase
      if (main_zero && irq_zero && s_q.phase_low)
      begin
        s_d.irq       = 1'b1;
        s_d.irq_cnt   = i_irq_period_reload;
        s_d.main_cnt  = i_high_phase_reload;
        // RULE6: shadow update
        s_d.hi_shadow = i_high_phase_reload;
        s_d.lo_shadow = i_low_phase_reload;
        s_d.phase_low = 1'b0;
        s_d.clk_half  = 1'b0;
      end
      else
      begin
        // RULE2: alternate reload
        if (main_zero)
        begin
          s_d.phase_low = ~s_q.phase_low;
          s_d.main_cnt  = s_q.phase_low ? s_q.hi_shadow : s_q.lo_shadow;
        end
        else
        begin
          // RULE14: value plus one clocks
          s_d.main_cnt = s_q.main_cnt - 16'h0001;
        end
        // RULE5: hold at zero
        if (irq_tick && !irq_zero)
        begin
          s_d.irq_cnt = s_q.irq_cnt - 16'h0001;
        end
      end
    end

    // ************************************************************
    // Timer 0 outputs
    // ************************************************************
    // RULE3: true output follows phase
    s_d.out_true = s_d.run && !s_d.phase_low;
    // RULE4: clock mode halves the tick
    if (i_t0_clock_mode && s_d.clk_half)
    begin
      s_d.out_true = 1'b0;
    end
    // RULE3: second output inverted
    s_d.out_inv  = ~s_d.out_true;

    // ************************************************************
    // Triple PWM
    // ************************************************************
    // RULE22: two-stage synchronizers
    s_d.rx_s1 = i_radio_rx_active;
    s_d.rx_s2 = s_q.rx_s1;
    s_d.tx_s1 = i_radio_tx_active;
    s_d.tx_s2 = s_q.tx_s1;
    s_d.tri_run = i_tri_on;
    if (!i_tri_on)
    begin
      s_d.tri_period_counter = TRI_RST_VAL;
      s_d.tri_out            = '0;
      s_d.tri_pre            = 3'h0;
    end
    else if (!s_q.tri_run)
    begin
      s_d.tri_period_counter = i_tri_period_value;
      s_d.tri_out            = '1;
    end
    else if (i_tri_period_value == TRI_RST_VAL)
    begin
      // RULE17: counters held while period is zero
      s_d.tri_period_counter = TRI_RST_VAL;
    end
    else if (tri_reload)
    begin
      // RULE16: period reload sets outputs high
      s_d.tri_period_counter = i_tri_period_value;
      s_d.tri_out            = '1;
    end
    else if (tri_tick)
    begin
      s_d.tri_period_counter = s_q.tri_period_counter - 14'h0001;
    end
    // RULE20: duty counter frozen by pause
    s_d.tri_duty_counter = duty_nxt;
    // RULE17: match clears output
    s_d.tri_out = s_d.tri_out & ~thr_hit;
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      // RULE7: zero after reset
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  logic [TRI_N-1:0] tri_o_q;
  logic [T0_W-1:0]  irqv_q;
  logic [T0_W-1:0]  mainv_q;
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      tri_o_q <= '0;
      irqv_q  <= T0_RST_VAL;
      mainv_q <= T0_RST_VAL;
    end
    else
    begin
      // RULE20: outputs forced low during pause
      tri_o_q <= paused ? '0 : s_d.tri_out;
      // RULE10: live counter views
      irqv_q  <= s_d.irq_cnt;
      mainv_q <= s_d.main_cnt;
    end
  end

  // ************************************************************
  // Port drive
  // ************************************************************
  assign o_t0_out_true     = s_q.out_true;
  assign o_t0_out_inverted = s_q.out_inv;
  assign o_t0_period_irq   = s_q.irq;
  assign o_irq_period_view = irqv_q;
  assign o_main_count_view = mainv_q;
  assign o_tri_out_n       = tri_o_q;

endmodule

// ==== dv/dpt_checker_assertions.sv ====
// Port assertions for the dual PWM timer
`timescale 1ns/1ps
module dpt_checker
  import dpt_pkg::*;
(
  input wire logic             i_mclk,
  input wire logic             i_nrst,
  input wire logic             i_t0_run,
  input wire logic             i_t0_fast_clock_select,
  input wire logic             i_periph_timer_clock_on,
  input wire logic [1:0]       i_periph_timer_divider,
  input wire logic             i_t0_clock_mode,
  input wire logic             i_t0_freeze,
  input wire logic [T0_W-1:0]  i_high_phase_reload,
  input wire logic [T0_W-1:0]  i_irq_period_reload,
  input wire logic             i_radio_pause_enable,
  input wire logic             i_auto_pause_allow,
  input wire logic             i_radio_rx_active,
  input wire logic             o_t0_out_true,
  input wire logic             o_t0_out_inverted,
  input wire logic             o_t0_period_irq,
  input wire logic [T0_W-1:0]  o_irq_period_view,
  input wire logic [T0_W-1:0]  o_main_count_view,
  input wire logic [TRI_N-1:0] o_tri_out_n
);
  // ****************
  // Timer properties
  // ****************
  logic fast1;
  assign fast1 = i_t0_run & i_t0_fast_clock_select & i_periph_timer_clock_on
               & (i_periph_timer_divider == DIV_1) & ~i_t0_freeze;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  sequence s_start;
    $rose(i_t0_run) && !i_t0_clock_mode && !i_t0_freeze;
  endsequence
  sequence s_paused;
    (i_radio_rx_active && i_radio_pause_enable && i_auto_pause_allow)[*4];
  endsequence
  property p_inv; $past(i_nrst) |-> o_t0_out_inverted == !o_t0_out_true;
  endproperty
  a_inv: assert property (p_inv) else $error("inverse output wrong");
  property p_start; s_start |=> o_t0_period_irq && o_t0_out_true;
  endproperty
  a_start: assert property (p_start) else $error("no start pulse");
  property p_load;
    s_start |=> o_main_count_view == $past(i_high_phase_reload)
      && o_irq_period_view == $past(i_irq_period_reload);
  endproperty
  a_load: assert property (p_load) else $error("bad start load");
  property p_off;
    !i_t0_run |=> !o_t0_out_true && !o_t0_period_irq
      && o_main_count_view == 16'h0000 && o_irq_period_view == 16'h0000;
  endproperty
  a_off: assert property (p_off) else $error("idle timer active");
  property p_freeze;
    i_t0_run && $past(i_t0_run) && $past(i_nrst) && i_t0_freeze
      |=> $stable(o_main_count_view) && $stable(o_irq_period_view);
  endproperty
  a_freeze: assert property (p_freeze) else $error("frozen count moved");
  property p_dec;
    fast1 && $past(fast1) && o_main_count_view != 16'h0000
      |=> o_main_count_view == $past(o_main_count_view) - 16'h0001;
  endproperty
  a_dec: assert property (p_dec) else $error("main count step wrong");
  property p_irq1; o_t0_period_irq |=> !o_t0_period_irq; endproperty
  a_irq1: assert property (p_irq1) else $error("irq too long");
  property p_irqrun; o_t0_period_irq |-> $past(i_t0_run); endproperty
  a_irqrun: assert property (p_irqrun) else $error("irq while off");
  property p_pause; s_paused |-> o_tri_out_n == 3'h0; endproperty
  a_pause: assert property (p_pause) else $error("pause not low");
endmodule

// ==== dv/dual_pwm_timers_bench.sv ====
// Self-checking bench for the dual PWM timer
`timescale 1ns/1ps
module dual_pwm_timers_bench
  import dpt_pkg::*;
;
  logic i_mclk, i_nrst, i_t0_run, i_t0_fast_clock_select;
  logic i_slow_clk = 1'b0;
  logic i_periph_timer_clock_on, i_irq_counter_div10, i_t0_clock_mode;
  logic i_t0_freeze, i_tri_on, i_radio_pause_enable, i_auto_pause_allow;
  logic i_radio_rx_active, i_radio_tx_active, o_t0_out_true;
  logic o_t0_out_inverted, o_t0_period_irq;
  logic [1:0]       i_periph_timer_divider;
  logic [T0_W-1:0]  i_high_phase_reload, i_low_phase_reload, v;
  logic [T0_W-1:0]  i_irq_period_reload, o_irq_period_view, o_main_count_view;
  logic [TRI_W-1:0] i_tri_period_value, i_tri_duty_threshold_0;
  logic [TRI_W-1:0] i_tri_duty_threshold_1, i_tri_duty_threshold_2;
  logic [TRI_N-1:0] o_tri_out_n;
  int               n_fail, checked, t, c0, c1, c2, cyc, scnt;
  dpt_top uut (.*);
  // ************
  // Access tasks
  // ************
  task automatic chk(input string nm, input logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_ok(input string nm, input logic ok);
    chk(nm, 16'h0001, {15'h0000, ok});
  endtask
  task automatic give_verdict;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wait_irq;
    t = 0;
    do
    begin
      @(negedge i_mclk);
      t++;
    end while (o_t0_period_irq !== 1'b1 && t < 5000);
  endtask
  task automatic phase(input logic lvl);
    t = 0;
    while (o_t0_out_true === lvl && t < 3000)
    begin
      t++;
      @(negedge i_mclk);
    end
  endtask
  task automatic count(input int n);
    {c0, c1, c2} = '0;
    repeat (n)
    begin
      @(negedge i_mclk);
      c0 += int'(o_tri_out_n[0] === 1'b1);
      c1 += int'(o_tri_out_n[1] === 1'b1);
      c2 += int'(o_tri_out_n[2] === 1'b1);
    end
  endtask
  initial
  begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk)
  begin
    cyc++;
    scnt = (scnt == 389) ? 0 : scnt + 1;
    if (scnt == 0)
      i_slow_clk <= ~i_slow_clk;
    if (cyc == 20000)
    begin
      n_fail++;
      give_verdict;
    end
  end
  initial
  begin
    {i_nrst, i_t0_run, i_t0_fast_clock_select,
     i_periph_timer_clock_on, i_irq_counter_div10, i_t0_clock_mode,
     i_t0_freeze, i_tri_on, i_radio_pause_enable, i_auto_pause_allow,
     i_radio_rx_active, i_radio_tx_active, i_periph_timer_divider,
     i_high_phase_reload, i_low_phase_reload, i_irq_period_reload,
     i_tri_period_value, i_tri_duty_threshold_0, i_tri_duty_threshold_1,
     i_tri_duty_threshold_2} = '0;
    {n_fail, checked} = '0;
    repeat (12) @(posedge i_mclk);
    i_nrst <= 1'b1;
    @(negedge i_mclk);
    chk("main view", 16'h0000, o_main_count_view);
    chk("period view", 16'h0000, o_irq_period_view);
    @(posedge i_mclk) i_t0_run <= 1'b1;
    wait_irq;
    wait_irq;
    wait_irq;
    chk_ok("slow period", t > 1554 && t < 1566);
    @(posedge i_mclk)
    begin
      i_t0_run <= 1'b0;
      {i_t0_fast_clock_select, i_periph_timer_clock_on} <= 2'h3;
      i_high_phase_reload <= 16'h0003;
      i_low_phase_reload <= 16'h0002;
    end
    @(posedge i_mclk) i_t0_run <= 1'b1;
    @(posedge i_mclk);
    @(negedge i_mclk);
    chk("start irq", 16'h0001, {15'h0000, o_t0_period_irq});
    chk("start load", 16'h0003, o_main_count_view);
    phase(1'b1);
    chk("high len", 16'h0004, t[15:0]);
    phase(1'b0);
    chk("low len", 16'h0003, t[15:0]);
    @(posedge i_mclk) i_high_phase_reload <= 16'h0005;
    @(negedge i_mclk);
    phase(1'b1);
    chk("old high rest", 16'h0003, t[15:0]);
    phase(1'b0);
    phase(1'b1);
    chk("new high", 16'h0006, t[15:0]);
    for (int d = 0; d < 4; d++)
    begin
      @(posedge i_mclk) i_periph_timer_divider <= 2'(d);
      wait_irq;
      wait_irq;
      chk("period", 16'(9 << d), t[15:0]);
      phase(1'b1);
      chk("high div", 16'(6 << d), t[15:0]);
    end
    @(posedge i_mclk) i_t0_freeze <= 1'b1;
    @(negedge i_mclk);
    v = o_main_count_view;
    repeat (20) @(negedge i_mclk);
    chk("frozen", v, o_main_count_view);
    @(posedge i_mclk) i_t0_freeze <= 1'b0;
    repeat (20) @(negedge i_mclk);
    chk_ok("thawed", o_main_count_view !== v);
    @(posedge i_mclk)
    begin
      i_periph_timer_divider <= DIV_1;
      i_t0_clock_mode <= 1'b1;
    end
    wait_irq;
    phase(1'b1);
    chk("clock high", 16'h0001, t[15:0]);
    phase(1'b0);
    chk("clock low", 16'h0001, t[15:0]);
    @(posedge i_mclk)
    begin
      i_t0_clock_mode <= 1'b0;
      i_irq_counter_div10 <= 1'b1;
      i_irq_period_reload <= 16'h0002;
    end
    wait_irq;
    wait_irq;
    chk_ok("div ten", t > 17 && t < 28);
    @(posedge i_mclk) i_t0_run <= 1'b0;
    @(posedge i_mclk);
    @(negedge i_mclk);
    chk("off view", 16'h0000, o_main_count_view);
    @(posedge i_mclk)
    begin
      i_periph_timer_divider <= DIV_1;
      i_tri_period_value <= 14'h0009;
      i_tri_duty_threshold_1 <= 14'h0003;
      i_tri_duty_threshold_2 <= 14'h0009;
      i_tri_on <= 1'b1;
    end
    count(100);
    chk("zero duty", 16'h0000, c0[15:0]);
    chk_ok("duty order", c1 > 0 && c1 < c2);
    @(posedge i_mclk) {i_radio_pause_enable, i_auto_pause_allow} <= 2'h3;
    @(posedge i_mclk) i_radio_rx_active <= 1'b1;
    repeat (5) @(negedge i_mclk);
    count(50);
    chk("rx paused", 16'h0000, 16'(c1 + c2));
    @(posedge i_mclk) i_auto_pause_allow <= 1'b0;
    count(100);
    chk_ok("pause off", c2 > 0);
    @(posedge i_mclk) {i_auto_pause_allow, i_radio_rx_active} <= 2'h2;
    @(posedge i_mclk) i_radio_tx_active <= 1'b1;
    repeat (5) @(negedge i_mclk);
    count(50);
    chk("tx paused", 16'h0000, 16'(c1 + c2));
    @(posedge i_mclk) i_radio_tx_active <= 1'b0;
    count(100);
    chk_ok("resumed", c2 > 0);
    give_verdict;
  end
endmodule
bind dpt_top dpt_checker u_chk (.*);
